//--- cmo_apb_slave.sv
`default_nettype none
module cmo_apb_slave (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	cmo_regbus_if.slave      bus
);
	typedef struct packed {
		logic [31:0] rdata;
		logic        err;
	} cmo_apb_s;

	cmo_apb_s st_r;
	cmo_apb_s st_nxt;
	logic     up_zero;

	// only the low byte of the address space is mapped
	assign up_zero   = (paddr[31:8] == 24'h000000);
	assign bus.addr  = paddr[7:0];
	assign bus.wdata = pwdata;
	// write lands at the completing access edge
	assign bus.wr    = psel & penable & pwrite & pstrb[0] & up_zero & bus.hit;

	// read data and error are captured in the setup cycle
	always_comb begin
		st_nxt = st_r;
		if (psel && !penable) begin
			st_nxt.rdata = pwrite ? 32'h00000000 : bus.rdata;
			st_nxt.err   = ~(up_zero & bus.hit);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata  = st_r.rdata;
	assign pready  = 1'b1;
	assign pslverr = st_r.err & psel & penable;
endmodule
`default_nettype wire

//--- cmo_can_node.sv
`default_nettype none
module cmo_can_node (
	input  wire logic       clk,
	input  wire logic       tx_start,
	input  wire logic       lose,
	output logic            rx_new,
	output logic      [1:0] rx_mb,
	output logic            rx_remote,
	output logic            rx_done,
	output logic            arb_lost,
	output logic            tx_done
);
	timeunit 1ns;
	timeprecision 1ps;
	// bus idle at start
	initial begin
		rx_new = 1'b0;
		rx_mb = 2'h0;
		rx_remote = 1'b0;
		rx_done = 1'b0;
		arb_lost = 1'b0;
		tx_done = 1'b0;
	end
	// one frame lands in a mailbox
	task automatic send_rx(input logic [1:0] mb, input logic rem);
		@(posedge clk);
		rx_new <= 1'b1;
		rx_mb <= mb;
		rx_remote <= rem;
		@(posedge clk);
		rx_new <= 1'b0;
		rx_mb <= ~mb;   // unqualified lines toggle
		rx_remote <= ~rem;
	endtask
	// answer each started frame
	always begin
		@(posedge clk);
		if (tx_start === 1'b1) begin
			repeat (6) @(posedge clk);
			if (lose) begin
				arb_lost <= 1'b1;
				@(posedge clk);
				arb_lost <= 1'b0;
				repeat (4) @(posedge clk);
				rx_done <= 1'b1;
			end else
				tx_done <= 1'b1;
			@(posedge clk);
			rx_done <= 1'b0;
			tx_done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- cmo_pkg.sv
`default_nettype none
package cmo_pkg;
	// mailbox geometry and register field widths
	localparam int          NUM_MB        = 4;
	localparam int          MB_IDX_W      = 2;
	localparam int          IRQ_W         = 3;
	localparam int          OVR_REG_W     = 8;

	// register byte offsets on the apb side
	localparam logic [7:0]  OFF_OVR       = 8'h00;
	localparam logic [7:0]  OFF_TXPEND    = 8'h04;
	localparam logic [7:0]  OFF_TXCAN     = 8'h08;
	localparam logic [7:0]  OFF_CANACK    = 8'h0c;
	localparam logic [7:0]  OFF_TRANSMIT_ACKNOWLEDGE     = 8'h10;
	localparam logic [7:0]  OFF_RXPEND    = 8'h14;
	localparam logic [7:0]  OFF_RFPEND    = 8'h18;
	localparam logic [7:0]  OFF_CTRL      = 8'h1c;
	localparam logic [7:0]  OFF_IRQ_STAT  = 8'h20;
	localparam logic [7:0]  OFF_IRQ_MASK  = 8'h24;
	localparam logic [7:0]  OFF_STATE     = 8'h28;

	// field positions
	localparam int          CTRL_NART_BIT = 0;
	localparam int          IRQ_EMPTY_BIT = 0;
	localparam int          IRQ_OVR_BIT   = 1;
	localparam int          IRQ_RX_BIT    = 2;
	localparam int          STATE_FSM_LSB = 0;
	localparam int          STATE_MB_LSB  = 4;
	localparam int          STATE_ACT_BIT = 8;

	// values after reset
	localparam logic [NUM_MB-1:0] RST_FLAGS = 4'h0;
	localparam logic              RST_NART  = 1'b0;
	localparam logic [IRQ_W-1:0]  RST_MASK  = 3'h0;

	typedef logic [NUM_MB-1:0]   cmo_mb_t;
	typedef logic [MB_IDX_W-1:0] cmo_idx_t;

	// transmit sequencer, gray along recv-arb-tx-rxframe
	typedef enum logic [1:0] {
		ST_RECV = 2'b00,
		ST_ARB  = 2'b01,
		ST_TX   = 2'b11,
		ST_RXF  = 2'b10
	} cmo_state_e;
endpackage
`default_nettype wire

//--- cmo_regbus_if.sv
`default_nettype none
interface cmo_regbus_if;
	logic        wr;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        hit;

	// bus side drives the request, register side answers
	modport slave (output wr, addr, wdata, input rdata, hit);
	modport regs  (input wr, addr, wdata, output rdata, hit);
endinterface
`default_nettype wire

//--- cmo_top.sv
// Notes on behaviour
// (RULE_01) new message on pending mailbox flags overrun
// (RULE_02) overrun flag cleared only by writing one
// (RULE_03) overrun register upper four bits read zero
// (RULE_04) arbitration loss stops transmit, starts receiving
// (RULE_05) cancel on loss if no-retransmit or cancel-request
// (RULE_06) cancel clears pending/request, sets ack, empty irq
// (RULE_07) cancelled transmission keeps transmit-acknowledge zero
// (RULE_08) after reception, arbitrate pending and transmit winner
// (RULE_09) no pending request after reception: resume receiving
// (RULE_10) writing zero leaves overrun flag unchanged
`default_nettype none
module cmo_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        rx_new,
	input  wire logic [1:0]  rx_mb,
	input  wire logic        rx_remote,
	input  wire logic        rx_done,
	input  wire logic        arb_lost,
	input  wire logic        tx_done,
	output logic             tx_start,
	output logic      [1:0]  tx_mb,
	output logic             tx_active,
	output logic             rx_mode
);
	// sequencer and software-owned control state
	typedef struct packed {
		cmo_pkg::cmo_state_e          fsm;
		cmo_pkg::cmo_idx_t            mb;
		cmo_pkg::cmo_mb_t             pend;
		cmo_pkg::cmo_mb_t             canreq;
		logic                         nart;
		logic [cmo_pkg::IRQ_W-1:0]    mask;
		logic                         start;
	} cmo_top_s;

	cmo_top_s                      st_r;
	cmo_top_s                      st_nxt;
	cmo_regbus_if                  rbus ();

	cmo_pkg::cmo_mb_t              ovr_q;
	cmo_pkg::cmo_mb_t              ack_q;
	cmo_pkg::cmo_mb_t              transmit_acknowledge_q;
	cmo_pkg::cmo_mb_t              rxp_q;
	cmo_pkg::cmo_mb_t              rfp_q;
	logic [cmo_pkg::IRQ_W-1:0]     istat_q;

	cmo_pkg::cmo_mb_t              ovr_set;
	cmo_pkg::cmo_mb_t              rxp_set;
	cmo_pkg::cmo_mb_t              rfp_set;
	cmo_pkg::cmo_mb_t              cancel_v;
	cmo_pkg::cmo_mb_t              done_v;
	logic [cmo_pkg::IRQ_W-1:0]     irq_set;

	cmo_pkg::cmo_mb_t              ovr_clr;
	cmo_pkg::cmo_mb_t              ack_clr;
	cmo_pkg::cmo_mb_t              transmit_acknowledge_clr;
	cmo_pkg::cmo_mb_t              rxp_clr;
	cmo_pkg::cmo_mb_t              rfp_clr;
	logic [cmo_pkg::IRQ_W-1:0]     istat_clr;

	cmo_pkg::cmo_mb_t              rx_dec;
	cmo_pkg::cmo_mb_t              tx_dec;
	cmo_pkg::cmo_mb_t              sw_pend_set;
	cmo_pkg::cmo_mb_t              sw_can_set;

	// lowest numbered pending mailbox wins internal arbitration
	function automatic cmo_pkg::cmo_idx_t pick_mb(input cmo_pkg::cmo_mb_t v);
		cmo_pkg::cmo_idx_t r;
		r = '0;
		for (int i = cmo_pkg::NUM_MB - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = cmo_pkg::cmo_idx_t'(i);
			end
		end
		return r;
	endfunction

	// one-hot decode of a mailbox index
	function automatic cmo_pkg::cmo_mb_t onehot(input cmo_pkg::cmo_idx_t idx);
		cmo_pkg::cmo_mb_t r;
		r      = '0;
		r[idx] = 1'b1;
		return r;
	endfunction

	// write strobe qualified by register offset
	function automatic logic wr_at(input logic wr, input logic [7:0] a, input logic [7:0] off);
		return wr & (a == off);
	endfunction

	// apb protocol handling
	cmo_apb_slave u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.bus     (rbus.slave)
	);

	assign rx_dec = onehot(rx_mb);
	assign tx_dec = onehot(st_r.mb);

	// receive events mark mailboxes pending
	// (RULE_01) overrun on pending mailbox
	always_comb begin
		ovr_set = '0;
		rxp_set = '0;
		rfp_set = '0;
		if (rx_new) begin
			ovr_set = rx_dec & (rxp_q | rfp_q);
			if (rx_remote) begin
				rfp_set = rx_dec;
			end else begin
				rxp_set = rx_dec;
			end
		end
	end

	// software write-one-to-clear vectors
	// (RULE_02) clear only by one
	// (RULE_10) zero bits ignored
	assign ovr_clr   = rbus.wdata[cmo_pkg::NUM_MB-1:0] & {cmo_pkg::NUM_MB{wr_at(rbus.wr, rbus.addr, cmo_pkg::OFF_OVR)}};
	assign ack_clr   = rbus.wdata[cmo_pkg::NUM_MB-1:0] & {cmo_pkg::NUM_MB{wr_at(rbus.wr, rbus.addr, cmo_pkg::OFF_CANACK)}};
	assign transmit_acknowledge_clr = rbus.wdata[cmo_pkg::NUM_MB-1:0] & {cmo_pkg::NUM_MB{wr_at(rbus.wr, rbus.addr, cmo_pkg::OFF_TRANSMIT_ACKNOWLEDGE)}};
	assign rxp_clr   = rbus.wdata[cmo_pkg::NUM_MB-1:0] & {cmo_pkg::NUM_MB{wr_at(rbus.wr, rbus.addr, cmo_pkg::OFF_RXPEND)}};
	assign rfp_clr   = rbus.wdata[cmo_pkg::NUM_MB-1:0] & {cmo_pkg::NUM_MB{wr_at(rbus.wr, rbus.addr, cmo_pkg::OFF_RFPEND)}};
	assign istat_clr = rbus.wdata[cmo_pkg::IRQ_W-1:0] & {cmo_pkg::IRQ_W{wr_at(rbus.wr, rbus.addr, cmo_pkg::OFF_IRQ_STAT)}};

	// software request and cancel writes, one bits set, cancel bits only for pending mailboxes
	assign sw_pend_set = rbus.wdata[cmo_pkg::NUM_MB-1:0] & {cmo_pkg::NUM_MB{wr_at(rbus.wr, rbus.addr, cmo_pkg::OFF_TXPEND)}};
	assign sw_can_set  = rbus.wdata[cmo_pkg::NUM_MB-1:0] & st_r.pend
		& {cmo_pkg::NUM_MB{wr_at(rbus.wr, rbus.addr, cmo_pkg::OFF_TXCAN)}};

	// cancellation and completion per mailbox
	always_comb begin
		cancel_v = '0;
		done_v   = '0;
		case (st_r.fsm)
			cmo_pkg::ST_TX: begin
				if (arb_lost) begin
					// (RULE_05) cancel after loss
					if (st_r.nart || st_r.canreq[st_r.mb]) begin
						cancel_v = tx_dec;
					end
				end else if (tx_done) begin
					done_v = tx_dec;
				end
			end
			cmo_pkg::ST_RECV, cmo_pkg::ST_RXF: begin
				// requests not on the bus cancel at once
				cancel_v = st_r.pend & st_r.canreq;
			end
			default: begin
				cancel_v = '0;
			end
		endcase
	end

	// interrupt events
	// (RULE_06) empty irq on cancel
	always_comb begin
		irq_set                         = '0;
		irq_set[cmo_pkg::IRQ_EMPTY_BIT] = |(cancel_v | done_v);
		irq_set[cmo_pkg::IRQ_OVR_BIT]   = |ovr_set;
		irq_set[cmo_pkg::IRQ_RX_BIT]    = rx_new;
	end

	// sticky flag banks
	cmo_w1c_bank #(.W(cmo_pkg::NUM_MB)) u_ovr (
		.clk   (pclk),
		.rst_n (presetn),
		.set   (ovr_set),
		.clr   (ovr_clr),
		.q     (ovr_q)
	);

	// (RULE_06) acknowledge on cancel
	cmo_w1c_bank #(.W(cmo_pkg::NUM_MB)) u_ack (
		.clk   (pclk),
		.rst_n (presetn),
		.set   (cancel_v),
		.clr   (ack_clr),
		.q     (ack_q)
	);

	// (RULE_07) only completions acknowledge
	cmo_w1c_bank #(.W(cmo_pkg::NUM_MB)) u_transmit_acknowledge (
		.clk   (pclk),
		.rst_n (presetn),
		.set   (done_v),
		.clr   (transmit_acknowledge_clr),
		.q     (transmit_acknowledge_q)
	);

	cmo_w1c_bank #(.W(cmo_pkg::NUM_MB)) u_rxp (
		.clk   (pclk),
		.rst_n (presetn),
		.set   (rxp_set),
		.clr   (rxp_clr),
		.q     (rxp_q)
	);

	cmo_w1c_bank #(.W(cmo_pkg::NUM_MB)) u_rfp (
		.clk   (pclk),
		.rst_n (presetn),
		.set   (rfp_set),
		.clr   (rfp_clr),
		.q     (rfp_q)
	);

	cmo_w1c_bank #(.W(cmo_pkg::IRQ_W)) u_istat (
		.clk   (pclk),
		.rst_n (presetn),
		.set   (irq_set),
		.clr   (istat_clr),
		.q     (istat_q)
	);

	// register read mux and address decode
	always_comb begin
		rbus.rdata = 32'h00000000;
		rbus.hit   = 1'b1;
		case (rbus.addr)
			cmo_pkg::OFF_OVR: begin
				// (RULE_03) reserved bits zero
				rbus.rdata[cmo_pkg::OVR_REG_W-1:0] = {4'h0, ovr_q};
			end
			cmo_pkg::OFF_TXPEND: begin
				rbus.rdata[cmo_pkg::NUM_MB-1:0] = st_r.pend;
			end
			cmo_pkg::OFF_TXCAN: begin
				rbus.rdata[cmo_pkg::NUM_MB-1:0] = st_r.canreq;
			end
			cmo_pkg::OFF_CANACK: begin
				rbus.rdata[cmo_pkg::NUM_MB-1:0] = ack_q;
			end
			cmo_pkg::OFF_TRANSMIT_ACKNOWLEDGE: begin
				rbus.rdata[cmo_pkg::NUM_MB-1:0] = transmit_acknowledge_q;
			end
			cmo_pkg::OFF_RXPEND: begin
				rbus.rdata[cmo_pkg::NUM_MB-1:0] = rxp_q;
			end
			cmo_pkg::OFF_RFPEND: begin
				rbus.rdata[cmo_pkg::NUM_MB-1:0] = rfp_q;
			end
			cmo_pkg::OFF_CTRL: begin
				rbus.rdata[cmo_pkg::CTRL_NART_BIT] = st_r.nart;
			end
			cmo_pkg::OFF_IRQ_STAT: begin
				rbus.rdata[cmo_pkg::IRQ_W-1:0] = istat_q;
			end
			cmo_pkg::OFF_IRQ_MASK: begin
				rbus.rdata[cmo_pkg::IRQ_W-1:0] = st_r.mask;
			end
			cmo_pkg::OFF_STATE: begin
				rbus.rdata[cmo_pkg::STATE_FSM_LSB+1:cmo_pkg::STATE_FSM_LSB] = st_r.fsm;
				rbus.rdata[cmo_pkg::STATE_MB_LSB+1:cmo_pkg::STATE_MB_LSB]   = st_r.mb;
				rbus.rdata[cmo_pkg::STATE_ACT_BIT]                          = (st_r.fsm == cmo_pkg::ST_TX);
			end
			default: begin
				rbus.hit = 1'b0;
			end
		endcase
	end

	// transmit sequencer and control registers
	always_comb begin
		st_nxt       = st_r;
		st_nxt.start = 1'b0;
		// completed or cancelled requests leave, new ones join
		// (RULE_06) clear pending and request
		st_nxt.pend   = (st_r.pend & ~(cancel_v | done_v)) | sw_pend_set;
		st_nxt.canreq = (st_r.canreq & ~(cancel_v | done_v)) | sw_can_set;
		if (wr_at(rbus.wr, rbus.addr, cmo_pkg::OFF_CTRL)) begin
			st_nxt.nart = rbus.wdata[cmo_pkg::CTRL_NART_BIT];
		end
		if (wr_at(rbus.wr, rbus.addr, cmo_pkg::OFF_IRQ_MASK)) begin
			st_nxt.mask = rbus.wdata[cmo_pkg::IRQ_W-1:0];
		end
		case (st_r.fsm)
			cmo_pkg::ST_RECV: begin
				if (|(st_r.pend & ~st_r.canreq)) begin
					st_nxt.fsm = cmo_pkg::ST_ARB;
				end
			end
			cmo_pkg::ST_ARB: begin
				// (RULE_08) pick and send winner
				if (|(st_r.pend & ~st_r.canreq)) begin
					st_nxt.mb    = pick_mb(st_r.pend & ~st_r.canreq);
					st_nxt.start = 1'b1;
					st_nxt.fsm   = cmo_pkg::ST_TX;
				end else begin
					st_nxt.fsm = cmo_pkg::ST_RECV;
				end
			end
			cmo_pkg::ST_TX: begin
				// (RULE_04) loss turns to reception
				if (arb_lost) begin
					st_nxt.fsm = cmo_pkg::ST_RXF;
				end else if (tx_done) begin
					st_nxt.fsm = cmo_pkg::ST_RECV;
				end
			end
			cmo_pkg::ST_RXF: begin
				if (rx_done) begin
					// (RULE_08) arbitrate after reception
					// (RULE_09) else back to receiving
					if (|(st_nxt.pend & ~st_nxt.canreq)) begin
						st_nxt.fsm = cmo_pkg::ST_ARB;
					end else begin
						st_nxt.fsm = cmo_pkg::ST_RECV;
					end
				end
			end
			default: begin
				st_nxt.fsm = cmo_pkg::ST_RECV;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.fsm    <= cmo_pkg::ST_RECV;
			st_r.mb     <= '0;
			st_r.pend   <= cmo_pkg::RST_FLAGS;
			st_r.canreq <= cmo_pkg::RST_FLAGS;
			st_r.nart   <= cmo_pkg::RST_NART;
			st_r.mask   <= cmo_pkg::RST_MASK;
			st_r.start  <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs toward the bit engine and the cpu
	assign tx_start  = st_r.start;
	assign tx_mb     = st_r.mb;
	assign tx_active = (st_r.fsm == cmo_pkg::ST_TX);
	assign rx_mode   = (st_r.fsm != cmo_pkg::ST_TX);
	assign irq       = |(istat_q & st_r.mask);
endmodule
`default_nettype wire

//--- cmo_top_sva.sv
`default_nettype none
module cmo_top_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        arb_lost,
	input wire logic        tx_done,
	input wire logic        tx_start,
	input wire logic        tx_active,
	input wire logic        rx_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// overrun status reads: upper bits never set
	a_ovr_reserved_zero: assert property (
		psel && !penable && !pwrite && paddr == 32'h0 |=> prdata[31:4] == 28'h0)
		else $error("overrun reserved bits read nonzero");
	// losing arbitration drops transmit for at least two cycles
	a_loss_to_rx: assert property (
		arb_lost && tx_active |=> (rx_mode && !tx_active) [*2])
		else $error("transmit kept after arbitration loss");
	// transmit holds until the bus answers
	a_tx_hold: assert property (
		tx_active && !arb_lost && !tx_done |=> tx_active)
		else $error("transmit dropped without cause");
	// receive mode only resumes after a loss or a completed frame
	a_leave_cause: assert property (
		$rose(rx_mode) |-> $past(arb_lost) || $past(tx_done))
		else $error("transmit left without loss or completion");
	// a good frame returns to receiving
	a_done_to_rx: assert property (
		tx_done && tx_active && !arb_lost |=> rx_mode [*2])
		else $error("no return to receive after frame");
	// start strobe lasts one cycle
	a_start_pulse: assert property (
		tx_start |=> !tx_start)
		else $error("start strobe longer than a cycle");
	// start coincides with entering transmit
	a_start_enter: assert property (
		tx_start |-> $rose(tx_active))
		else $error("start without entering transmit");
	a_enter_cause: assert property (
		$rose(tx_active) |-> tx_start)
		else $error("transmit entered without start");
	c_loss: cover property (arb_lost && tx_active);
	c_done: cover property (tx_done && tx_active);
	c_err: cover property (psel && penable && pslverr);
endmodule
bind cmo_top cmo_top_sva cmo_top_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .arb_lost(arb_lost),
	.tx_done(tx_done), .tx_start(tx_start), .tx_active(tx_active), .rx_mode(rx_mode));
`default_nettype wire

//--- cmo_unused_placeholder.sv
`default_nettype none
`default_nettype wire

//--- cmo_w1c_bank.sv
`default_nettype none
module cmo_w1c_bank #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] flags;
	} cmo_w1c_s;

	cmo_w1c_s st_r;
	cmo_w1c_s st_nxt;

	// clear by one, a same-cycle event wins over the clear
	always_comb begin
		st_nxt       = st_r;
		st_nxt.flags = (st_r.flags & ~clr) | set;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.flags;
endmodule
`default_nettype wire

//--- tb_top.sv
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("wrong value t=%0t %h %h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, lose;
	logic        rx_new, rx_remote, rx_done, arb_lost, tx_done, tx_start, tx_active, rx_mode;
	logic [1:0]  rx_mb, tx_mb;
	logic [31:0] paddr, pwdata, prdata;
	int          fails, checks;

	cmo_top cmo_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .rx_new(rx_new), .rx_mb(rx_mb), .rx_remote(rx_remote), .rx_done(rx_done),
		.arb_lost(arb_lost), .tx_done(tx_done), .tx_start(tx_start), .tx_mb(tx_mb),
		.tx_active(tx_active), .rx_mode(rx_mode));
	cmo_can_node cmo_can_node_inst (.clk(pclk), .tx_start(tx_start), .lose(lose), .rx_new(rx_new),
		.rx_mb(rx_mb), .rx_remote(rx_remote), .rx_done(rx_done), .arb_lost(arb_lost), .tx_done(tx_done));

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		`CHK(q, x)
	endtask
	task automatic wait_start(input logic [1:0] mb);
		int n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (tx_start !== 1'b1 && n < 50);
		`CHK(tx_start, 1'b1)
		`CHK(tx_mb, mb)
	endtask
	// reset value and unmapped access
	task automatic t_reset_map;
		logic [31:0] q;
		logic        e;
		rd(cmo_pkg::OFF_OVR, 32'h0);
		apb(1'b0, 8'h30, 32'h0, q, e);
		`CHK(e, 1'b1)
	endtask
	// overrun flags, interrupt and clearing
	task automatic t_overrun;
		cmo_can_node_inst.send_rx(2'h1, 1'b0);
		cmo_can_node_inst.send_rx(2'h1, 1'b0);
		cmo_can_node_inst.send_rx(2'h2, 1'b1);
		cmo_can_node_inst.send_rx(2'h2, 1'b1);
		cmo_can_node_inst.send_rx(2'h3, 1'b0);
		wr(cmo_pkg::OFF_RXPEND, 32'h8);
		cmo_can_node_inst.send_rx(2'h3, 1'b0);
		rd(cmo_pkg::OFF_OVR, 32'h6);
		rd(cmo_pkg::OFF_IRQ_STAT, 32'h6);
		`CHK(irq, 1'b0)
		wr(cmo_pkg::OFF_IRQ_MASK, 32'h2);
		@(negedge pclk);
		`CHK(irq, 1'b1)
		wr(cmo_pkg::OFF_IRQ_STAT, 32'h6);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		wr(cmo_pkg::OFF_OVR, 32'h2);
		rd(cmo_pkg::OFF_OVR, 32'h4);
		wr(cmo_pkg::OFF_OVR, 32'hf0);
		rd(cmo_pkg::OFF_OVR, 32'h4);
	endtask
	// plain successful frame
	task automatic t_tx_ok;
		wr(cmo_pkg::OFF_TXPEND, 32'h1);
		wait_start(2'h0);
		repeat (12) @(posedge pclk);
		rd(cmo_pkg::OFF_TRANSMIT_ACKNOWLEDGE, 32'h1);
		rd(cmo_pkg::OFF_TXPEND, 32'h0);
		wr(cmo_pkg::OFF_IRQ_STAT, 32'h1);
	endtask
	// loss with retransmit disabled cancels
	task automatic t_cancel_nart;
		wr(cmo_pkg::OFF_CTRL, 32'h1);
		wr(cmo_pkg::OFF_IRQ_MASK, 32'h1);
		lose <= 1'b1;
		wr(cmo_pkg::OFF_TXPEND, 32'h4);
		wait_start(2'h2);
		repeat (9) @(negedge pclk);
		`CHK(rx_mode, 1'b1)
		`CHK(irq, 1'b1)
		repeat (8) @(posedge pclk);
		rd(cmo_pkg::OFF_CANACK, 32'h4);
		rd(cmo_pkg::OFF_TXPEND, 32'h0);
		rd(cmo_pkg::OFF_TRANSMIT_ACKNOWLEDGE, 32'h1);
		rd(cmo_pkg::OFF_STATE, 32'h20);
		wr(cmo_pkg::OFF_IRQ_STAT, 32'h1);
		wr(cmo_pkg::OFF_CTRL, 32'h0);
	endtask
	// cancel request on the bus, other pending mailbox sent after the reception
	task automatic t_retry_cancel;
		wr(cmo_pkg::OFF_TXPEND, 32'ha);
		wait_start(2'h1);
		wr(cmo_pkg::OFF_TXCAN, 32'h2);
		repeat (5) @(negedge pclk);
		@(posedge pclk);
		lose <= 1'b0;
		wait_start(2'h3);
		repeat (12) @(posedge pclk);
		rd(cmo_pkg::OFF_CANACK, 32'h6);
		rd(cmo_pkg::OFF_TRANSMIT_ACKNOWLEDGE, 32'h9);
		rd(cmo_pkg::OFF_TXPEND, 32'h0);
		rd(cmo_pkg::OFF_TXCAN, 32'h0);
	endtask
	// loss without cancel keeps the request, a waiting one cancels at once
	task automatic t_retry_keep;
		wr(cmo_pkg::OFF_CANACK, 32'hf);
		wr(cmo_pkg::OFF_TRANSMIT_ACKNOWLEDGE, 32'hf);
		lose <= 1'b1;
		wr(cmo_pkg::OFF_TXPEND, 32'h5);
		wait_start(2'h0);
		repeat (8) @(posedge pclk);
		lose <= 1'b0;
		wr(cmo_pkg::OFF_TXCAN, 32'h4);
		`CHK(tx_active, 1'b0)
		wait_start(2'h0);
		repeat (12) @(posedge pclk);
		rd(cmo_pkg::OFF_CANACK, 32'h4);
		rd(cmo_pkg::OFF_TRANSMIT_ACKNOWLEDGE, 32'h1);
		rd(cmo_pkg::OFF_TXPEND, 32'h0);
	endtask
	task tally_and_finish;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// free-running clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		lose = 1'b0;
		fails = 0;
		checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_map();
		t_overrun();
		t_tx_ok();
		t_cancel_nart();
		t_retry_cancel();
		t_retry_keep();
		tally_and_finish();
	end
	// watchdog
	initial begin
		#40000;
		fails++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
